// ---- inc/lto_pkg.sv ----
// package of opcode patterns, flag masks and decoder types for the literal/table decoder
package lto_pkg;

    // ************************************************************
    // instruction word fields
    // ************************************************************
    localparam int LTO_WORD_W = 16;
    localparam int LTO_BYTE_W = 8;
    localparam int LTO_PTR_LIT_W = 12;
    localparam int LTO_BANK_W = 4;
    localparam int LTO_PSEL_W = 2;
    // upper-byte opcode patterns; bank load matches the upper 12 bits
    localparam logic [7:0] LTO_OP_ADD = 8'h0F;
    localparam logic [7:0] LTO_OP_AND = 8'h0B;
    localparam logic [7:0] LTO_OP_OR = 8'h09;
    localparam logic [7:0] LTO_OP_XOR = 8'h0A;
    localparam logic [7:0] LTO_OP_SUB = 8'h08;
    localparam logic [7:0] LTO_OP_MOV = 8'h0E;
    localparam logic [7:0] LTO_OP_MUL = 8'h0D;
    localparam logic [7:0] LTO_OP_RET = 8'h0C;
    localparam logic [11:0] LTO_OP_BANK = 12'h010;
    // pointer load first word: upper 10 bits, second word upper byte
    localparam logic [9:0] LTO_OP_PTR1 = 10'h3B8;
    localparam logic [7:0] LTO_OP_PTR2 = 8'hF0;
    // table access: upper 13 bits, bit 2 selects write
    localparam logic [12:0] LTO_OP_TBL = 13'h0001;
    // flag mask bit positions
    localparam int LTO_F_C = 0;
    localparam int LTO_F_DC = 1;
    localparam int LTO_F_Z = 2;
    localparam int LTO_F_OV = 3;
    localparam int LTO_F_N = 4;
    localparam logic [4:0] LTO_FLAGS_ARITH = 5'h1F;
    localparam logic [4:0] LTO_FLAGS_LOGIC = 5'h14;
    localparam logic [4:0] LTO_FLAGS_NONE = 5'h00;
    // cycle counts
    localparam logic [1:0] LTO_CYC_ONE = 2'h1;
    localparam logic [1:0] LTO_CYC_TWO = 2'h2;
    // reset values
    localparam logic [1:0] LTO_RST_PREV = 2'h0;

    // ************************************************************
    // types
    // ************************************************************
    // alu operation selector
    typedef enum logic [3:0] {
        LTO_ALU_NONE, LTO_ALU_ADD, LTO_ALU_AND, LTO_ALU_OR, LTO_ALU_XOR,
        LTO_ALU_SUB, LTO_ALU_MOV, LTO_ALU_MUL
    } lto_alu_e;

    // table pointer adjustment
    typedef enum logic [1:0] {
        LTO_TP_NONE, LTO_TP_POSTINC, LTO_TP_POSTDEC, LTO_TP_PREINC
    } lto_tp_e;

    // decoded controls for the datapath
    typedef struct packed {
        lto_alu_e alu_op;        // operation on working register
        logic [7:0] literal;     // 8-bit literal
        logic [4:0] flag_mask;   // status flags updated
        logic working_register_write;        // working register written
        logic bank_write;        // bank select register low nibble written
        logic [3:0] bank_val;    // bank value
        logic ret;               // return from subroutine
        logic tbl_read;          // table read
        logic tbl_write;         // table write
        lto_tp_e tbl_ptr;        // pointer adjustment
        logic ptr_load;          // indirect pointer load
        logic [1:0] ptr_sel;     // indirect pointer select
        logic [11:0] ptr_val;    // 12-bit pointer literal
        logic [1:0] cycles;      // cycles the instruction takes
        logic nop;               // executes as no-operation
    } lto_ctl_s;
endpackage

// ---- src/lto_field_dec.sv ----
// single-word field decoder for literal and table operations
`timescale 1ns/1ps
module lto_field_dec
    import lto_pkg::*;
(
    // instruction word
    input wire logic [15:0] word_in,
    // decoded result
    output lto_ctl_s ctl_out,
    output logic first_of_two_out
);

    // ************************************************************
    // combinational decode
    // ************************************************************
    always_comb
    begin
        ctl_out = '0;
        ctl_out.literal = word_in[7:0];
        ctl_out.cycles = LTO_CYC_ONE;
        ctl_out.nop = 1'b1;
        first_of_two_out = 1'b0;
        case (word_in[15:8])
            LTO_OP_ADD:
            begin
                ctl_out.alu_op = LTO_ALU_ADD;
                ctl_out.flag_mask = LTO_FLAGS_ARITH;
                ctl_out.working_register_write = 1'b1;
                ctl_out.nop = 1'b0;
            end
            LTO_OP_AND:
            begin
                ctl_out.alu_op = LTO_ALU_AND;
                ctl_out.flag_mask = LTO_FLAGS_LOGIC;
                ctl_out.working_register_write = 1'b1;
                ctl_out.nop = 1'b0;
            end
            LTO_OP_OR:
            begin
                ctl_out.alu_op = LTO_ALU_OR;
                ctl_out.flag_mask = LTO_FLAGS_LOGIC;
                ctl_out.working_register_write = 1'b1;
                ctl_out.nop = 1'b0;
            end
            LTO_OP_XOR:
            begin
                ctl_out.alu_op = LTO_ALU_XOR;
                ctl_out.flag_mask = LTO_FLAGS_LOGIC;
                ctl_out.working_register_write = 1'b1;
                ctl_out.nop = 1'b0;
            end
            LTO_OP_SUB:
            begin
                ctl_out.alu_op = LTO_ALU_SUB;
                ctl_out.flag_mask = LTO_FLAGS_ARITH;
                ctl_out.working_register_write = 1'b1;
                ctl_out.nop = 1'b0;
            end
            LTO_OP_MOV:
            begin
                ctl_out.alu_op = LTO_ALU_MOV;
                ctl_out.working_register_write = 1'b1;
                ctl_out.nop = 1'b0;
            end
            LTO_OP_MUL:
            begin
                // product lands in the product pair, not the working register
                ctl_out.alu_op = LTO_ALU_MUL;
                ctl_out.nop = 1'b0;
            end
            LTO_OP_RET:
            begin
                ctl_out.alu_op = LTO_ALU_MOV;
                ctl_out.working_register_write = 1'b1;
                ctl_out.ret = 1'b1;
                ctl_out.cycles = LTO_CYC_TWO;
                ctl_out.nop = 1'b0;
            end
            default:
            begin
                if (word_in[15:4] == LTO_OP_BANK)
                begin
                    ctl_out.bank_write = 1'b1;
                    ctl_out.bank_val = word_in[3:0];
                    ctl_out.nop = 1'b0;
                end
                else if (word_in[15:3] == LTO_OP_TBL)
                begin
                    ctl_out.tbl_read = ~word_in[2];
                    ctl_out.tbl_write = word_in[2];
                    ctl_out.tbl_ptr = lto_tp_e'(word_in[1:0]);
                    ctl_out.cycles = LTO_CYC_TWO;
                    ctl_out.nop = 1'b0;
                end
                else if (word_in[15:6] == LTO_OP_PTR1)
                begin
                    first_of_two_out = 1'b1;
                    ctl_out.ptr_sel = word_in[5:4];
                    ctl_out.ptr_val = {word_in[3:0], 8'h00};
                    ctl_out.cycles = LTO_CYC_TWO;
                    ctl_out.nop = 1'b0;
                end
            end
        endcase
    end

endmodule // lto_field_dec

// ---- src/lto_decoder.sv ----
// literal-operation and table-access instruction decoder top
`timescale 1ns/1ps
module lto_decoder
    import lto_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_in,
    // fetch side
    input wire logic word_valid_in,
    input wire logic [15:0] word_in,
    // datapath feedback
    input wire logic pc_modified_in,
    input wire logic cond_true_in,
    input wire logic port_self_mod_in,
    input wire logic [7:0] port_pins_in,
    input wire logic [7:0] port_latch_in,
    input wire logic timer_zero_count_file_write_in,
    input wire logic prescaler_on_timer_zero_count_in,
    // decoded controls
    output lto_ctl_s ctl_out,
    output logic ctl_valid_out,
    output logic flush_out,
    output logic [7:0] port_operand_out,
    output logic prescaler_clear_out
);

    // ************************************************************
    // state
    // ************************************************************
    typedef enum logic [1:0] {
        LTO_ST_RUN,    // normal single-word decode
        LTO_ST_WORD2,  // expecting second word of pointer load
        LTO_ST_FLUSH   // second cycle executes as no-op
    } lto_state_e;

    lto_state_e state_ff; // decoder state
    lto_ctl_s ctl_ff; // registered controls
    logic valid_ff; // registered valid
    logic flush_ff; // flush indicator
    logic [7:0] port_op_ff; // registered port operand
    logic pclr_ff; // prescaler clear pulse
    lto_ctl_s dec_ctl; // raw decode
    logic dec_first; // word opens a two-word instruction
    lto_ctl_s nxt_ctl; // next controls

    // single-word field decoder
    lto_field_dec u_dec (
        .word_in(word_in),
        .ctl_out(dec_ctl),
        .first_of_two_out(dec_first)
    );

    // ************************************************************
    // next controls
    // ************************************************************
    always_comb
    begin
        nxt_ctl = dec_ctl;
        case (state_ff)
            LTO_ST_WORD2:
            begin
                // second word carries the low literal byte
                nxt_ctl = ctl_ff;
                nxt_ctl.ptr_val = {ctl_ff.ptr_val[11:8], word_in[7:0]};
                nxt_ctl.ptr_load = (word_in[15:8] == LTO_OP_PTR2);
                nxt_ctl.nop = (word_in[15:8] != LTO_OP_PTR2);
            end
            LTO_ST_FLUSH:
            begin
                nxt_ctl = '0;
                nxt_ctl.nop = 1'b1;
                nxt_ctl.cycles = LTO_CYC_ONE;
            end
            default:
            begin
                // a lone second word decodes to nothing: harmless no-op
                if (word_in[15:8] == LTO_OP_PTR2)
                begin
                    nxt_ctl = '0;
                    nxt_ctl.nop = 1'b1;
                    nxt_ctl.cycles = LTO_CYC_ONE;
                end
            end
        endcase
    end

    // ************************************************************
    // state sequencing
    // ************************************************************
    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in)
            state_ff <= LTO_ST_RUN;
        else if (word_valid_in)
        begin
            case (state_ff)
                LTO_ST_RUN:
                    if (dec_first)
                        state_ff <= LTO_ST_WORD2;
                    else if (dec_ctl.cycles == LTO_CYC_TWO || pc_modified_in || cond_true_in)
                        state_ff <= LTO_ST_FLUSH;
                LTO_ST_WORD2:
                    state_ff <= LTO_ST_RUN;
                LTO_ST_FLUSH:
                    state_ff <= LTO_ST_RUN;
                default:
                    state_ff <= LTO_ST_RUN;
            endcase
        end
    end

    // ************************************************************
    // control outputs
    // ************************************************************
    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in)
        begin
            ctl_ff <= '0;
            valid_ff <= 1'b0;
            flush_ff <= 1'b0;
        end
        else
        begin
            valid_ff <= word_valid_in;
            if (word_valid_in)
            begin
                ctl_ff <= nxt_ctl;
                flush_ff <= (state_ff == LTO_ST_FLUSH);
            end
        end
    end

    // ************************************************************
    // port operand and timer prescaler
    // ************************************************************
    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in)
            port_op_ff <= 8'h00;
        else
            port_op_ff <= port_self_mod_in ? port_pins_in : port_latch_in;
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in)
            pclr_ff <= 1'b0;
        else
            pclr_ff <= timer_zero_count_file_write_in & prescaler_on_timer_zero_count_in;
    end

    assign ctl_out = ctl_ff;
    assign ctl_valid_out = valid_ff;
    assign flush_out = flush_ff;
    assign port_operand_out = port_op_ff;
    assign prescaler_clear_out = pclr_ff;

    // ************************************************************
    // assertions
    // ************************************************************
    add_flags_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        valid_ff && ctl_ff.alu_op == LTO_ALU_ADD |-> ctl_ff.flag_mask == 5'h1F)
        else $error("add literal flag mask wrong");
    logic_flags_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        valid_ff && (ctl_ff.alu_op == LTO_ALU_AND || ctl_ff.alu_op == LTO_ALU_XOR)
        |-> ctl_ff.flag_mask == 5'h14)
        else $error("logic literal flag mask wrong");
    or_flags_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        valid_ff && ctl_ff.alu_op == LTO_ALU_OR |-> ctl_ff.flag_mask == 5'h14)
        else $error("or literal flag mask wrong");
    sub_flags_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        valid_ff && ctl_ff.alu_op == LTO_ALU_SUB |-> ctl_ff.flag_mask == 5'h1F && ctl_ff.working_register_write)
        else $error("subtract literal controls wrong");
    mov_flags_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        valid_ff && (ctl_ff.alu_op == LTO_ALU_MOV || ctl_ff.alu_op == LTO_ALU_MUL) |-> ctl_ff.flag_mask == 5'h00)
        else $error("move or multiply touched flags");
    bank_load_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        word_valid_in && state_ff == LTO_ST_RUN && word_in[15:4] == 12'h010
        |=> ctl_ff.bank_write && ctl_ff.bank_val == $past(word_in[3:0]))
        else $error("bank load not decoded");
    sequence two_cycle_s;
        word_valid_in && state_ff == LTO_ST_RUN && !dec_first && dec_ctl.cycles == LTO_CYC_TWO;
    endsequence
    flush_follow_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        two_cycle_s ##1 word_valid_in |=> flush_out && ctl_out.nop)
        else $error("second cycle not flushed");
    ptr_pair_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        word_valid_in && state_ff == LTO_ST_RUN && dec_first ##1 word_valid_in && word_in[15:8] == 8'hF0
        |=> ctl_out.ptr_load && ctl_out.ptr_val[7:0] == $past(word_in[7:0]))
        else $error("pointer load pair not assembled");
    orphan_nop_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        word_valid_in && state_ff == LTO_ST_RUN && word_in[15:8] == 8'hF0 |=> ctl_out.nop)
        else $error("orphan second word not a no-op");
    port_pins_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        port_self_mod_in |=> port_operand_out == $past(port_pins_in))
        else $error("port operand not from pins");
    pre_clear_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        timer_zero_count_file_write_in && prescaler_on_timer_zero_count_in |=> prescaler_clear_out)
        else $error("prescaler not cleared");

    // ************************************************************
    // per-operation control checks
    // ************************************************************

    // exclusive or touches only zero and negative
    xor_flags_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        valid_ff && ctl_ff.alu_op == LTO_ALU_XOR |-> ctl_ff.flag_mask == LTO_FLAGS_LOGIC)
        else $error("xor literal flag mask wrong");

    // bank load is a single cycle with no flag update
    bank_flags_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        valid_ff && ctl_ff.bank_write |-> ctl_ff.flag_mask == LTO_FLAGS_NONE && ctl_ff.cycles == LTO_CYC_ONE)
        else $error("bank load controls wrong");

    // product goes elsewhere, so no working register write and no flags
    mul_quiet_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        valid_ff && ctl_ff.alu_op == LTO_ALU_MUL |-> !ctl_ff.working_register_write && ctl_ff.flag_mask == LTO_FLAGS_NONE)
        else $error("multiply literal controls wrong");

    // return loads the literal, takes two cycles, leaves flags
    ret_two_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        valid_ff && ctl_ff.ret |-> ctl_ff.cycles == LTO_CYC_TWO && ctl_ff.working_register_write
        && ctl_ff.flag_mask == LTO_FLAGS_NONE)
        else $error("return with literal controls wrong");

    // first pointer word only announces the pair
    ptr_first_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        word_valid_in && state_ff == LTO_ST_RUN && dec_first
        |=> ctl_out.cycles == LTO_CYC_TWO && !ctl_out.ptr_load)
        else $error("pointer first word controls wrong");

    // any table access is two cycles and flag-free
    tbl_cycles_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        valid_ff && (ctl_ff.tbl_read || ctl_ff.tbl_write)
        |-> ctl_ff.cycles == LTO_CYC_TWO && ctl_ff.flag_mask == LTO_FLAGS_NONE)
        else $error("table access controls wrong");

    // a write never also reads
    tbl_excl_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        valid_ff && ctl_ff.tbl_write |-> !ctl_ff.tbl_read)
        else $error("table read and write both set");

    // datapath redirect on a plain word
    sequence redirect_s;
        word_valid_in && state_ff == LTO_ST_RUN && !dec_first && (pc_modified_in || cond_true_in);
    endsequence

    // the word after a redirect is swallowed as a no-op
    pc_flush_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        redirect_s ##1 word_valid_in |=> flush_out && ctl_out.nop && !ctl_out.working_register_write)
        else $error("redirect follower not flushed");

endmodule // lto_decoder

// ---- verification/lto_fetch_model.sv ----
// fetch unit and datapath model that feeds words to the decoder
`timescale 1ns/1ps
module lto_fetch_model
(
    // clock
    input wire logic clk_in,
    // fetch and datapath side
    output logic word_valid_out,
    output logic [15:0] word_out,
    output logic pc_mod_out,
    output logic cond_out
);
    // queued words, test flag and pc flag in bits 17:16
    logic [17:0] q[$];

    // queue one word with its datapath qualifiers
    task automatic push(input logic [15:0] w, input logic pc, input logic ct);
        q.push_back({ct, pc, w});
    endtask

    // idle bus at time zero
    initial
    begin
        word_valid_out = 1'b0;
        word_out = 16'h0000;
        pc_mod_out = 1'b0;
        cond_out = 1'b0;
    end

    // one word per falling edge; a released bus inverts every bit of its word on each idle falling edge
    always @(negedge clk_in)
    begin
        if (q.size() > 0)
        begin
            {cond_out, pc_mod_out, word_out} <= q.pop_front();
            word_valid_out <= 1'b1;
        end
        else
        begin
            word_out <= ~word_out;
            {word_valid_out, pc_mod_out, cond_out} <= 3'h0;
        end
    end
endmodule // lto_fetch_model

// ---- verification/tb_top.sv ----
// self-checking testbench for the literal and table decoder
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; $display("Error t=%0t got %0h exp %0h", $time, g, e); end end
module tb_top;
    import lto_pkg::*;
    // ************************************************************
    // clock, reset and wiring
    // ************************************************************
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic self_mod = 1'b0;
    logic [7:0] pins = 8'h00;
    logic [7:0] latch = 8'h00;
    logic timer_zero_count_wr = 1'b0;
    logic pre_on = 1'b0;
    logic word_valid;
    logic pc_mod;
    logic cond;
    logic [15:0] word;
    lto_ctl_s ctl;
    logic ctl_valid;
    logic flush;
    logic pre_clr;
    logic [7:0] port_op;
    int n_mismatch = 0;
    int checked = 0;

    // clock at 40 ns
    initial
    begin
        forever #20 ref_clk = ~ref_clk;
    end

    lto_fetch_model fetch (.clk_in(ref_clk), .word_valid_out(word_valid), .word_out(word),
        .pc_mod_out(pc_mod), .cond_out(cond));

    lto_decoder uut (.ref_clk_in(ref_clk), .reset_in(reset), .word_valid_in(word_valid), .word_in(word),
        .pc_modified_in(pc_mod), .cond_true_in(cond), .port_self_mod_in(self_mod), .port_pins_in(pins),
        .port_latch_in(latch), .timer_zero_count_file_write_in(timer_zero_count_wr), .prescaler_on_timer_zero_count_in(pre_on),
        .ctl_out(ctl), .ctl_valid_out(ctl_valid), .flush_out(flush), .port_operand_out(port_op),
        .prescaler_clear_out(pre_clr));

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic tick();
        @(negedge ref_clk);
    endtask

    // verdict and end of run
    task automatic finish_test();
        if (n_mismatch == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // literal used for op i, with both byte limits
    function automatic logic [7:0] lit(int i);
        return (i == 0) ? 8'h00 : 8'hF9 + 8'(i);
    endfunction

    // one-cycle register operation
    task automatic chk_alu(lto_alu_e a, logic [7:0] l, logic [4:0] m, logic w);
        `CHK(ctl_valid, 1'b1)
        `CHK(flush, 1'b0)
        `CHK(ctl.alu_op, a)
        `CHK(ctl.literal, l)
        `CHK(ctl.flag_mask, m)
        `CHK(ctl.working_register_write, w)
        `CHK(ctl.cycles, LTO_CYC_ONE)
    endtask

    // flushed second cycle
    task automatic chk_flush();
        `CHK(flush, 1'b1)
        `CHK(ctl.nop, 1'b1)
        `CHK(ctl.working_register_write, 1'b0)
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    // all one-cycle literal ops back to back
    task automatic test_literal();
        logic [7:0] op [7];
        lto_alu_e al [7];
        logic [4:0] fm [7];
        op = '{LTO_OP_ADD, LTO_OP_AND, LTO_OP_OR, LTO_OP_XOR, LTO_OP_SUB, LTO_OP_MOV, LTO_OP_MUL};
        al = '{LTO_ALU_ADD, LTO_ALU_AND, LTO_ALU_OR, LTO_ALU_XOR, LTO_ALU_SUB, LTO_ALU_MOV, LTO_ALU_MUL};
        fm = '{5'h1F, 5'h14, 5'h14, 5'h14, 5'h1F, 5'h00, 5'h00};
        @(posedge ref_clk);
        for (int i = 0; i < 7; i++)
            fetch.push({op[i], lit(i)}, 1'b0, 1'b0);
        tick();
        for (int i = 0; i < 7; i++)
        begin
            tick();
            chk_alu(al[i], lit(i), fm[i], i != 6);
        end
    endtask

    // bank load, return with literal, flushed follower
    task automatic test_bank_ret();
        @(posedge ref_clk);
        fetch.push(16'h010F, 1'b0, 1'b0);
        fetch.push(16'h0C3C, 1'b0, 1'b0);
        fetch.push(16'h0F77, 1'b0, 1'b0);
        fetch.push(16'h0E11, 1'b0, 1'b0);
        tick();
        tick();
        `CHK({ctl.bank_write, ctl.bank_val, ctl.flag_mask, ctl.cycles}, {1'b1, 4'hF, 5'h00, 2'h1})
        tick();
        `CHK({ctl.ret, ctl.working_register_write, ctl.literal, ctl.flag_mask, ctl.cycles}, {2'h3, 8'h3C, 5'h00, 2'h2})
        tick();
        chk_flush();
        tick();
        chk_alu(LTO_ALU_MOV, 8'h11, 5'h00, 1'b1);
    endtask

    // every table read and write mode, each followed by a flushed word
    task automatic test_table();
        @(posedge ref_clk);
        for (int i = 0; i < 8; i++)
        begin
            fetch.push(16'h0008 + 16'(i), 1'b0, 1'b0);
            fetch.push(16'h0F00 + 16'(i), 1'b0, 1'b0);
        end
        tick();
        for (int i = 0; i < 8; i++)
        begin
            tick();
            `CHK({ctl.tbl_read, ctl.tbl_write}, (i < 4) ? 2'h2 : 2'h1)
            `CHK(ctl.tbl_ptr, lto_tp_e'(i % 4))
            `CHK({ctl.cycles, ctl.flag_mask}, {2'h2, 5'h00})
            tick();
            chk_flush();
        end
    endtask

    // two-word pointer load, orphan second word, unknown word
    task automatic test_ptr();
        @(posedge ref_clk);
        fetch.push(16'hEE3A, 1'b0, 1'b0);
        fetch.push(16'hF05C, 1'b0, 1'b0);
        fetch.push(16'hF0FF, 1'b0, 1'b0);
        fetch.push(16'hFFFF, 1'b0, 1'b0);
        fetch.push(16'h0F01, 1'b0, 1'b0);
        tick();
        tick();
        `CHK({ctl.ptr_load, ctl.cycles}, {1'b0, 2'h2})
        tick();
        `CHK({ctl.ptr_load, ctl.ptr_sel, ctl.ptr_val, ctl.flag_mask}, {1'b1, 2'h3, 12'hA5C, 5'h00})
        tick();
        `CHK({ctl.nop, ctl.ptr_load, ctl.working_register_write, flush}, 4'h8)
        tick();
        `CHK({ctl.nop, ctl.working_register_write, ctl.tbl_read, ctl.tbl_write}, 4'h8)
        tick();
        chk_alu(LTO_ALU_ADD, 8'h01, 5'h1F, 1'b1);
    endtask

    // pc change and true test each flush the next word
    task automatic test_pc_cond();
        @(posedge ref_clk);
        fetch.push(16'h0F10, 1'b1, 1'b0);
        fetch.push(16'h0E20, 1'b0, 1'b0);
        fetch.push(16'h0F30, 1'b0, 1'b1);
        fetch.push(16'h0B40, 1'b0, 1'b0);
        fetch.push(16'h0A50, 1'b0, 1'b0);
        tick();
        tick();
        chk_alu(LTO_ALU_ADD, 8'h10, 5'h1F, 1'b1);
        tick();
        chk_flush();
        tick();
        chk_alu(LTO_ALU_ADD, 8'h30, 5'h1F, 1'b1);
        tick();
        chk_flush();
        tick();
        chk_alu(LTO_ALU_XOR, 8'h50, 5'h14, 1'b1);
    endtask

    // port operand select and prescaler clear over all qualifier mixes
    task automatic test_port();
        for (int i = 0; i < 8; i++)
        begin
            pins = 8'h5A + 8'(i);
            latch = ~pins;
            {pre_on, timer_zero_count_wr, self_mod} = 3'(i);
            tick();
            `CHK(port_op, self_mod ? pins : latch)
            `CHK(pre_clr, timer_zero_count_wr & pre_on)
        end
        {pre_on, timer_zero_count_wr} = 2'h0;
        tick();
        `CHK(pre_clr, 1'b0)
    endtask

    // ************************************************************
    // main sequence and watchdog
    // ************************************************************
    initial
    begin
        repeat (16) @(posedge ref_clk);
        tick();
        reset = 1'b0;
        `CHK({ctl_valid, flush, pre_clr, ctl}, '0)
        test_literal();
        test_bank_ret();
        test_table();
        test_ptr();
        test_pc_cond();
        test_port();
        finish_test();
    end

    // about fifteen times the expected run
    initial
    begin
        repeat (1000) @(posedge ref_clk);
        n_mismatch++;
        finish_test();
    end
endmodule // tb_top
